//--- hw/nvc_regs.svh
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

// Register locations: bit 8 is the data memory sector, bits 7..0 the offset
`define NVC_SECTOR_W        1
`define NVC_OFFSET_W        8
`define NVC_ADDR_REG_LOC    9'h041
`define NVC_DATA_REG_LOC    9'h042
`define NVC_CTRL_REG_LOC    9'h140

// Store geometry
`define NVC_DEPTH           64
`define NVC_AW              6
`define NVC_DW              8

// Control register field positions
`define NVC_CTRL_WR_EN_BIT  3
`define NVC_CTRL_WR_BIT     2
`define NVC_CTRL_RD_EN_BIT  1
`define NVC_CTRL_RD_BIT     0

// Reset values
`define NVC_ADDR_RST        6'h00
`define NVC_DATA_RST        8'h00
`define NVC_CTRL_RST        4'h0
`define NVC_UNMAPPED_VAL    8'h00

// Timing: read completes this many system clocks after it is launched
`define NVC_READ_CYCLES     2
// Default write time in slow subsidiary clock cycles
`define NVC_WRITE_SUB_CYC   64

`endif

//--- hw/nvc_pkg.sv
`default_nettype none

package nvc_pkg;

    // Gray coded along idle -> read/write -> idle
    typedef enum logic [1:0] {
        NVC_IDLE  = 2'b00,
        NVC_READ  = 2'b01,
        NVC_WRITE = 2'b10
    } nvc_state_t;

endpackage

`default_nettype wire

//--- hw/nvc_timer_if.sv
`timescale 1ns/100ps
`default_nettype none

interface nvc_timer_if;
    logic start;
    logic busy;
    logic done;

    modport ctrl
    (
        output start,
        input  busy,
        input  done
    );

    modport timer
    (
        input  start,
        output busy,
        output done
    );
endinterface

`default_nettype wire

//--- hw/nvc_write_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvc_regs.svh"

module nvc_write_timer
    import nvc_pkg::*;
#(
    parameter int WRITE_SUB_CYC = `NVC_WRITE_SUB_CYC
)
(
    input  wire logic      ref_clk_i,
    input  wire logic      srst_i,
    input  wire logic      sub_clk_i,
    nvc_timer_if.timer     tmr
);

    localparam int CW = $clog2(WRITE_SUB_CYC + 1);

    // Elaboration check on the write time
    if (WRITE_SUB_CYC < 1)
    begin
        $error("WRITE_SUB_CYC must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow clock synchroniser and rising edge detect

    logic [2:0]    sub_sync_r;
    logic [2:0]    sub_sync_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          busy_r;
    logic          busy_nxt;
    logic          done_r;
    logic          done_nxt;
    logic          sub_edge;

    // Edge is taken between second and third stage only
    assign sub_edge = sub_sync_r[1] & ~sub_sync_r[2];

    ////////////////////////////////////////////////////////////////////////
    // Counter of slow clock cycles

    always_comb
    begin
        sub_sync_nxt = {sub_sync_r[1:0], sub_clk_i};
        cnt_nxt      = cnt_r;
        busy_nxt     = busy_r;
        done_nxt     = 1'b0;
        if (!busy_r && tmr.start)
        begin
            busy_nxt = 1'b1;
            cnt_nxt  = CW'(WRITE_SUB_CYC);
        end
        else if (busy_r && sub_edge)
        begin
            // Completion is produced in the system clock domain
            if (cnt_r == CW'(1))
            begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            sub_sync_r <= 3'h0;
            cnt_r      <= '0;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
        end
        else
        begin
            sub_sync_r <= sub_sync_nxt;
            cnt_r      <= cnt_nxt;
            busy_r     <= busy_nxt;
            done_r     <= done_nxt;
        end
    end

    assign tmr.busy = busy_r;
    assign tmr.done = done_r;

endmodule

`default_nettype wire

//--- hw/nvc_ctrl.sv
// Operation
// - 64 bytes, single byte access, not mapped
// - Address register six bits, upper read zero
// - Data register eight bits, reset zero
// - Address and data in sector zero
// - Control register at sector one 40H
// - Control bits 7..4 read zero
// - Write enable flag gates write launch
// - Write start needs enable; hardware clears it
// - Read enable flag gates read launch
// - Read start needs enable; hardware clears it
// - Read fetches byte as start clears
// - Read data held until next operation
// - Write timed asynchronously by internal timer
// - Write end sets done and shared flags
`timescale 1ns/100ps
`default_nettype none
`include "nvc_regs.svh"

module nvc_ctrl
    import nvc_pkg::*;
#(
    parameter int WRITE_SUB_CYC = `NVC_WRITE_SUB_CYC,
    parameter int READ_CYCLES   = `NVC_READ_CYCLES
)
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     srst_i,
    input  wire logic                     sub_clk_i,
    input  wire logic [8:0]               sfr_addr_i,
    input  wire logic                     sfr_wr_i,
    input  wire logic                     sfr_rd_i,
    input  wire logic [`NVC_DW-1:0]       sfr_wdata_i,
    output logic      [`NVC_DW-1:0]       sfr_rdata_o,
    input  wire logic                     write_done_flag_clr_i,
    output logic                          write_done_flag_o,
    output logic                          mf_req_set_o,
    output logic                          nv_busy_o
);

    localparam int RCW = $clog2(READ_CYCLES + 1);

    // Elaboration checks on the parameters
    if (READ_CYCLES < 1)
    begin
        $error("READ_CYCLES must be at least 1");
    end

    if (WRITE_SUB_CYC < 1)
    begin
        $error("WRITE_SUB_CYC must be at least 1");
    end

    // Every address value must select a stored byte
    if (`NVC_DEPTH != (1 << `NVC_AW))
    begin
        $error("store depth does not match address width");
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [`NVC_DW-1:0] nv_mem [`NVC_DEPTH];

    nvc_timer_if tmr_if ();

    nvc_write_timer #(
        .WRITE_SUB_CYC (WRITE_SUB_CYC)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .sub_clk_i (sub_clk_i),
        .tmr       (tmr_if.timer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers

    nvc_state_t         state_r;
    nvc_state_t         state_nxt;
    logic [`NVC_AW-1:0] nv_address_r;
    logic [`NVC_AW-1:0] nv_address_nxt;
    logic [`NVC_DW-1:0] nv_data_r;
    logic [`NVC_DW-1:0] nv_data_nxt;
    logic               write_enable_flag_r;
    logic               write_enable_flag_nxt;
    logic               wr_start_r;
    logic               wr_start_nxt;
    logic               read_enable_flag_r;
    logic               read_enable_flag_nxt;
    logic               rd_start_r;
    logic               rd_start_nxt;
    logic [RCW-1:0]     rd_cnt_r;
    logic [RCW-1:0]     rd_cnt_nxt;
    logic [`NVC_AW-1:0] wr_addr_r;
    logic [`NVC_AW-1:0] wr_addr_nxt;
    logic [`NVC_DW-1:0] wr_data_r;
    logic [`NVC_DW-1:0] wr_data_nxt;
    logic               write_done_flag_r;
    logic               write_done_flag_nxt;
    logic               mf_req_r;
    logic               mf_req_nxt;
    logic [`NVC_DW-1:0] rdata_r;
    logic [`NVC_DW-1:0] rdata_nxt;
    logic               tmr_start;
    logic               mem_we;

    logic               hit_addr;
    logic               hit_data;
    logic               hit_ctrl;
    logic [`NVC_DW-1:0] ctrl_view;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb
    begin
        hit_addr = 1'b0;
        hit_data = 1'b0;
        hit_ctrl = 1'b0;
        if (sfr_addr_i == `NVC_ADDR_REG_LOC)
            hit_addr = 1'b1;
        else if (sfr_addr_i == `NVC_DATA_REG_LOC)
            hit_data = 1'b1;
        else if (sfr_addr_i == `NVC_CTRL_REG_LOC)
            hit_ctrl = 1'b1;
    end

    // Upper control bits are not stored and read as zero
    assign ctrl_view = {4'h0, write_enable_flag_r, wr_start_r,
                        read_enable_flag_r, rd_start_r};

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_nxt             = state_r;
        nv_address_nxt        = nv_address_r;
        nv_data_nxt           = nv_data_r;
        write_enable_flag_nxt = write_enable_flag_r;
        wr_start_nxt          = wr_start_r;
        read_enable_flag_nxt  = read_enable_flag_r;
        rd_start_nxt          = rd_start_r;
        rd_cnt_nxt            = rd_cnt_r;
        wr_addr_nxt           = wr_addr_r;
        wr_data_nxt           = wr_data_r;
        write_done_flag_nxt   = write_done_flag_r;
        mf_req_nxt            = 1'b0;
        rdata_nxt             = rdata_r;
        tmr_start             = 1'b0;
        mem_we                = 1'b0;

        // Software writes
        if (sfr_wr_i && hit_addr)
            nv_address_nxt = sfr_wdata_i[`NVC_AW-1:0];
        if (sfr_wr_i && hit_data)
            nv_data_nxt = sfr_wdata_i;
        if (sfr_wr_i && hit_ctrl)
        begin
            write_enable_flag_nxt = sfr_wdata_i[`NVC_CTRL_WR_EN_BIT];
            read_enable_flag_nxt  = sfr_wdata_i[`NVC_CTRL_RD_EN_BIT];
            // Starts launch only from idle with the enable already set
            if (state_r == NVC_IDLE)
            begin
                if (sfr_wdata_i[`NVC_CTRL_WR_BIT] && write_enable_flag_r)
                begin
                    wr_start_nxt = 1'b1;
                    wr_addr_nxt  = nv_address_r;
                    wr_data_nxt  = nv_data_r;
                    tmr_start    = 1'b1;
                    state_nxt    = NVC_WRITE;
                end
                else if (sfr_wdata_i[`NVC_CTRL_RD_BIT] && read_enable_flag_r)
                begin
                    rd_start_nxt = 1'b1;
                    rd_cnt_nxt   = RCW'(READ_CYCLES);
                    state_nxt    = NVC_READ;
                end
            end
        end

        case (state_r)
            NVC_READ:
            begin
                if (rd_cnt_r == RCW'(1))
                begin
                    // Byte lands in data register as the start bit clears
                    nv_data_nxt  = nv_mem[nv_address_r];
                    rd_start_nxt = 1'b0;
                    state_nxt    = NVC_IDLE;
                end
                rd_cnt_nxt = rd_cnt_r - RCW'(1);
            end
            NVC_WRITE:
            begin
                if (tmr_if.done)
                begin
                    mem_we       = 1'b1;
                    wr_start_nxt = 1'b0;
                    mf_req_nxt   = 1'b1;
                    state_nxt    = NVC_IDLE;
                end
            end
            NVC_IDLE:
            begin
                state_nxt = state_nxt;
            end
            default:
            begin
                // Unused code falls back to idle
                state_nxt = NVC_IDLE;
            end
        endcase

        // Done flag sticks; a set in the clearing cycle wins
        if (write_done_flag_clr_i)
            write_done_flag_nxt = 1'b0;
        if (mem_we)
            write_done_flag_nxt = 1'b1;

        // Registered read port, unmapped locations read zero
        if (sfr_rd_i)
        begin
            if (hit_addr)
                rdata_nxt = {2'h0, nv_address_r};
            else if (hit_data)
                rdata_nxt = nv_data_r;
            else if (hit_ctrl)
                rdata_nxt = ctrl_view;
            else
                rdata_nxt = `NVC_UNMAPPED_VAL;
        end
    end

    assign tmr_if.start = tmr_start;

    ////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state_r             <= NVC_IDLE;
            nv_address_r        <= `NVC_ADDR_RST;
            nv_data_r           <= `NVC_DATA_RST;
            {write_enable_flag_r, wr_start_r,
             read_enable_flag_r, rd_start_r} <= `NVC_CTRL_RST;
            rd_cnt_r            <= '0;
            wr_addr_r           <= `NVC_ADDR_RST;
            wr_data_r           <= `NVC_DATA_RST;
            write_done_flag_r   <= 1'b0;
            mf_req_r            <= 1'b0;
            rdata_r             <= `NVC_UNMAPPED_VAL;
        end
        else
        begin
            state_r             <= state_nxt;
            nv_address_r        <= nv_address_nxt;
            nv_data_r           <= nv_data_nxt;
            write_enable_flag_r <= write_enable_flag_nxt;
            wr_start_r          <= wr_start_nxt;
            read_enable_flag_r  <= read_enable_flag_nxt;
            rd_start_r          <= rd_start_nxt;
            rd_cnt_r            <= rd_cnt_nxt;
            wr_addr_r           <= wr_addr_nxt;
            wr_data_r           <= wr_data_nxt;
            write_done_flag_r   <= write_done_flag_nxt;
            mf_req_r            <= mf_req_nxt;
            rdata_r             <= rdata_nxt;
        end
    end

    // Nonvolatile array keeps its contents through reset
    always_ff @(posedge ref_clk_i)
    begin
        if (mem_we)
            nv_mem[wr_addr_r] <= wr_data_r;
    end

    assign sfr_rdata_o       = rdata_r;
    assign write_done_flag_o = write_done_flag_r;
    assign mf_req_set_o      = mf_req_r;
    assign nv_busy_o         = (state_r != NVC_IDLE);

endmodule

`default_nettype wire

//--- verif/nvc_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none

module nvc_ctrl_sva
    import nvc_pkg::*;
#(
    parameter int WRITE_SUB_CYC = 3,
    parameter int READ_CYCLES   = 2
)
(
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic       sub_clk_i,
    input wire logic [8:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       write_done_flag_clr_i,
    input wire logic       write_done_flag_o,
    input wire logic       mf_req_set_o,
    input wire logic       nv_busy_o
);
    // Shadow of the two enable flags, bit 1 write, bit 0 read
    logic [1:0] en_r;
    logic [1:0] en_nxt;
    logic       c_wr;
    logic [2:0] st;

    assign c_wr = sfr_wr_i && sfr_addr_i == 9'h140;
    assign st   = sfr_wdata_i[2:0];

    always_comb
    begin
        en_nxt = c_wr ? {sfr_wdata_i[3], sfr_wdata_i[1]} : en_r;
    end

    always_ff @(posedge ref_clk_i)
    begin
        en_r <= srst_i ? 2'h0 : en_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    property p_unmapped;
        sfr_rd_i && !(sfr_addr_i inside {9'h041, 9'h042, 9'h140}) |=> sfr_rdata_o == 8'h00;
    endproperty
    property p_addr_hi;
        sfr_rd_i && sfr_addr_i == 9'h041 |=> sfr_rdata_o[7:6] == 2'h0;
    endproperty
    property p_ctrl_hi;
        sfr_rd_i && sfr_addr_i == 9'h140 |=> sfr_rdata_o[7:4] == 4'h0;
    endproperty
    property p_hold;
        !sfr_rd_i |=> $stable(sfr_rdata_o);
    endproperty
    property p_wr_refused;
        c_wr && st == 3'b100 && !en_r[1] && !nv_busy_o |=> !nv_busy_o;
    endproperty
    property p_rd_refused;
        c_wr && st == 3'b001 && !en_r[0] && !nv_busy_o |=> !nv_busy_o;
    endproperty
    property p_rd_time;
        c_wr && !st[2] && st[0] && en_r[0] && !nv_busy_o |=> nv_busy_o[*2] ##1 !nv_busy_o;
    endproperty
    property p_wr_time;
        c_wr && st == 3'b100 && en_r[1] && !nv_busy_o |=> nv_busy_o[*8] ##[1:400] mf_req_set_o;
    endproperty
    property p_done;
        mf_req_set_o |-> (write_done_flag_o && !nv_busy_o) ##1 !mf_req_set_o;
    endproperty
    property p_sticky;
        write_done_flag_o && !write_done_flag_clr_i |=> write_done_flag_o;
    endproperty

    a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
    a_addr_hi:    assert property (p_addr_hi) else $error("address upper bits set");
    a_ctrl_hi:    assert property (p_ctrl_hi) else $error("control upper bits set");
    a_hold:       assert property (p_hold) else $error("read data changed");
    a_wr_refused: assert property (p_wr_refused) else $error("write launched unenabled");
    a_rd_refused: assert property (p_rd_refused) else $error("read launched unenabled");
    a_rd_time:    assert property (p_rd_time) else $error("read cycle length wrong");
    a_wr_time:    assert property (p_wr_time) else $error("write cycle timing wrong");
    a_done:       assert property (p_done) else $error("write end flags wrong");
    a_sticky:     assert property (p_sticky) else $error("done flag dropped");

    c_read:  cover property (c_wr && !st[2] && st[0] && en_r[0]);
    c_write: cover property (mf_req_set_o);
    c_clear: cover property (write_done_flag_o && write_done_flag_clr_i);
endmodule

`default_nettype wire

//--- verif/nvc_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none

module nvc_ctrl_test
    import nvc_pkg::*;
;
    logic       ref_clk_i;
    logic       srst_i;
    logic       sub_clk_i;
    logic [8:0] sfr_addr_i;
    logic       sfr_wr_i;
    logic       sfr_rd_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic       write_done_flag_clr_i;
    logic       write_done_flag_o;
    logic       mf_req_set_o;
    logic       nv_busy_o;
    int         fails;
    int         n_compared;
    int         cyc;
    logic [5:0] wa [3];
    logic [7:0] wd [3];

    nvc_ctrl #(.WRITE_SUB_CYC(3)) u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sub_clk_i(sub_clk_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .write_done_flag_clr_i(write_done_flag_clr_i),
        .write_done_flag_o(write_done_flag_o), .mf_req_set_o(mf_req_set_o), .nv_busy_o(nv_busy_o));

    always #2 ref_clk_i = ~ref_clk_i;
    always #20 sub_clk_i = ~sub_clk_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One register access: strobe for one edge, then one idle edge
    task automatic acc(input logic [8:0] a, input logic w, input logic [7:0] d);
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = w;
        sfr_rd_i    = !w;
        @(posedge ref_clk_i);
        #1;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic rc(input logic [8:0] a, input logic [7:0] e);
        acc(a, 1'b0, 8'h00);
        chk(sfr_rdata_o, e);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (nv_busy_o !== 1'b0 && n < 500)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (n >= 500)
            fails++;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {ref_clk_i, sub_clk_i, sfr_wr_i, sfr_rd_i, write_done_flag_clr_i} = 5'h0;
        srst_i      = 1'b1;
        sfr_addr_i  = 9'h000;
        sfr_wdata_i = 8'h00;
        {fails, n_compared, cyc} = {32'd0, 32'd0, 32'd0};
        wa = '{6'h00, 6'h3f, 6'h15};
        wd = '{8'h3c, 8'hc3, 8'h96};
        repeat (6) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        rc(9'h041, 8'h00);
        rc(9'h042, 8'h00);
        rc(9'h140, 8'h00);
        rc(9'h040, 8'h00);
        rc(9'h141, 8'h00);
        rc(9'h001, 8'h00);
        acc(9'h041, 1'b1, 8'hff);
        rc(9'h041, 8'h3f);
        acc(9'h042, 1'b1, 8'h5a);
        rc(9'h042, 8'h5a);
        acc(9'h140, 1'b1, 8'hf4);
        rc(9'h140, 8'h00);
        acc(9'h140, 1'b1, 8'h01);
        rc(9'h140, 8'h00);
        chk({7'h0, nv_busy_o}, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            acc(9'h041, 1'b1, {2'b00, wa[i]});
            acc(9'h042, 1'b1, wd[i]);
            acc(9'h140, 1'b1, 8'h08);
            acc(9'h140, 1'b1, 8'h0c);
            rc(9'h140, 8'h0c);
            wait_idle();
            chk({7'h0, mf_req_set_o}, 8'h01);
            chk({7'h0, write_done_flag_o}, 8'h01);
            rc(9'h140, 8'h08);
            write_done_flag_clr_i = 1'b1;
            @(posedge ref_clk_i);
            #1;
            write_done_flag_clr_i = 1'b0;
            chk({7'h0, write_done_flag_o}, 8'h00);
            chk({7'h0, mf_req_set_o}, 8'h00);
        end
        for (int i = 0; i < 3; i++)
        begin
            acc(9'h140, 1'b1, 8'h02);
            acc(9'h041, 1'b1, {2'b00, wa[i]});
            acc(9'h140, 1'b1, 8'h03);
            wait_idle();
            rc(9'h140, 8'h02);
            rc(9'h042, wd[i]);
            rc(9'h041, {2'b00, wa[i]});
            rc(9'h042, wd[i]);
        end
        acc(9'h140, 1'b1, 8'h00);
        stop_test();
    end
endmodule

bind nvc_ctrl nvc_ctrl_sva #(.WRITE_SUB_CYC(WRITE_SUB_CYC), .READ_CYCLES(READ_CYCLES)) u_sva (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sub_clk_i(sub_clk_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .write_done_flag_clr_i(write_done_flag_clr_i), .write_done_flag_o(write_done_flag_o),
    .mf_req_set_o(mf_req_set_o), .nv_busy_o(nv_busy_o));

`default_nettype wire
